// ---- shared/host_port_defs.svh ----
// constants of the host serial datagram port: timing counts and reset values
// assumes inclusion by bare name; holds definitions only
`ifndef HOST_PORT_DEFS_SVH
`define HOST_PORT_DEFS_SVH

// datagram geometry, msb first on the wire
`define DGRAM_BITS 32
`define DGRAM_MSB 31
`define DGRAM_COUNT_FULL 6'h20
`define REPLY_STATUS_BITS 8
`define REPLY_DATA_BITS 24

// shortest wait from a falling serial clock at the pin to the next out bit
`define SDO_MIN_DELAY_CYC 4
// cycles spent in the two sync stages, the edge compare and the arm flop
`define SDO_PIPE_CYC 4
// extra cycles of wait after the pipeline, derived from the two above
`define SDO_WAIT_CYC (2'(`SDO_MIN_DELAY_CYC - `SDO_PIPE_CYC))

// reset values: the datagram buffer clears, the chain clock prescaler loads fifteen
`define CHAIN_PRESCALER_RESET 4'hf
`define DGRAM_RESET 32'h0000_0000

// datagram that carries the chain clock prescaler (register space, rrs 0)
`define PRESCALER_ADDR 6'h3f
`define PRESCALER_LSB 0

`endif

// ---- shared/host_port_pkg.sv ----
// types of the host serial datagram port
// assumes host_port_defs.svh sits beside it on the include path
package host_port_pkg;

    // datagram as received from the host, bit 31 first on the wire
    typedef struct packed {
        logic rrs;              // 1 selects on-chip ram, 0 registers
        logic [5:0] address;    // register or ram address
        logic rw;               // 1 read, 0 write
        logic [23:0] data;      // write data, don't care on reads
    } datagram_t;

    // datagram returned to the host
    typedef struct packed {
        logic [7:0] status;     // status bits, sent first
        logic [23:0] data;      // requested read data
    } reply_t;

    // host pins after synchronisation
    typedef struct packed {
        logic sclk;
        logic select_n;
        logic sdi;
    } host_pins_t;

    typedef enum logic [0:0] {
        st_idle,
        st_receive
    } port_mode_t;

    // complete state of the port
    typedef struct packed {
        port_mode_t mode;
        logic sclk_q;
        logic select_n_q;
        logic [31:0] rx_shift;
        logic [5:0] bit_count;
        logic [31:0] tx_shift;
        logic shift_armed;
        logic [1:0] wait_count;
        datagram_t buffer;
        logic buffer_valid;
        logic chain_update;
        logic [3:0] chain_clock_prescaler;
    } port_regs_t;

endpackage

// ---- rtl/host_pin_sync.sv ----
// two-flop synchroniser for the three host serial inputs
// assumes the pins are asynchronous to core_clk; pins idle high
`timescale 1ns/10ps

module host_pin_sync
(
    input wire logic core_clk,                    // device clock
    input wire logic reset_n,                     // async reset, low
    input wire host_port_pkg::host_pins_t pins,   // raw pins
    output host_port_pkg::host_pins_t pins_sync   // second flop
);

    typedef struct packed {
        host_port_pkg::host_pins_t meta;
        host_port_pkg::host_pins_t stable;
    } sync_regs_t;

    sync_regs_t r_reg;
    sync_regs_t r_next;

    // meta feeds only the stable stage, nothing else looks at it
    always_comb
    begin
        r_next = r_reg;
        r_next.meta = pins;
        r_next.stable = r_reg.meta;
    end

    // reset to the idle level so no false edge appears at release
    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            r_reg <= {3'h7, 3'h7};
        end
        else
        begin
            r_reg <= r_next;
        end
    end

    assign pins_sync = r_reg.stable;

endmodule // host_pin_sync

// ---- rtl/host_serial_datagram_port.sv ----
// host-facing four-wire serial datagram port of the motion controller
// assumes serial pins asynchronous to core_clk, serial clock phases of at
// least three core_clk cycles, and an internal power-on reset on reset_n
`timescale 1ns/10ps
`include "host_port_defs.svh"

// Functional notes
// - host is master of this port; device masters the driver chain.
// - reset clears all bits, except chain clock prescaler loads fifteen, and the sclk and select copies and every pin synchroniser flop load high.
// - incoming bits collect in a 32-bit shift register.
// - one input bit shifts in on each of the first 32 rising serial clock edges of a frame.
// - select rising after 32 bits copies shift register into buffer, acted upon.
// - reply is captured as select falls, so read data returns on serial output during the next datagram.
// - next output bit appears at least four cycles after clock falls.
// - tristate output copy is undriven while select is high.
// - tristate copy never carries interrupt, only return data.
// - a configuration bit puts the interrupt straight on combined pin.
// - driver chain update requested only when new data arrives.
// - every exchange is exactly one 32-bit datagram.
// - with select high the combined pin shows active-low interrupt.
// - bits travel most significant first, least significant last.
// - reply holds read data low 24 bits, status high 8 bits.
// - read/write bit set means read, cleared means write.
module host_serial_datagram_port
(
    input wire logic core_clk,                  // device clock, 50 MHz
    input wire logic reset_n,                   // power-on reset, low
    input wire logic host_sclk,                 // serial clock pin
    input wire logic host_select_n,             // chip select pin, low
    input wire logic host_serial_in,            // serial data pin
    input wire logic irq_n,                     // interrupt, low active
    input wire logic irq_direct,                // pin carries irq only
    input wire logic [7:0] reply_status,        // status for the reply
    input wire logic [23:0] reply_data,         // read data for reply
    output logic irq_or_serial_out_pin,         // combined output pin
    output logic host_serial_out_tristate,      // tristate copy, data
    output logic host_serial_out_tristate_oe,   // tristate copy enable
    output host_port_pkg::datagram_t datagram,  // buffered datagram
    output logic datagram_valid,                // one-cycle strobe
    output logic chain_update,                  // chain send request
    output logic [3:0] chain_clock_prescaler    // chain clock divider
);

    host_port_pkg::host_pins_t pins_sync;
    host_port_pkg::port_regs_t r_reg;
    host_port_pkg::port_regs_t r_next;
    host_port_pkg::reply_t reply;
    logic sclk_rise;
    logic sclk_fall;
    logic select_fall;
    logic select_rise;
    logic selected;

    // raw pins are only read through the synchroniser
    host_pin_sync pin_sync
    (
        .core_clk(core_clk),
        .reset_n(reset_n),
        .pins({host_sclk, host_select_n, host_serial_in}),
        .pins_sync(pins_sync)
    );

    // edges of the synchronised pins against one more registered copy
    assign sclk_rise = !r_reg.sclk_q && pins_sync.sclk;
    assign sclk_fall = r_reg.sclk_q && !pins_sync.sclk;
    assign select_fall = r_reg.select_n_q && !pins_sync.select_n;
    assign select_rise = !r_reg.select_n_q && pins_sync.select_n;
    assign selected = (r_reg.mode == host_port_pkg::st_receive);

    // status on top, read data below, msb leaves first
    assign reply.status = reply_status;
    assign reply.data = reply_data;

    // next state of the whole port
    always_comb
    begin
        r_next = r_reg;
        r_next.sclk_q = pins_sync.sclk;
        r_next.select_n_q = pins_sync.select_n;
        r_next.buffer_valid = 1'b0;
        r_next.chain_update = 1'b0;
        unique case (r_reg.mode)
            host_port_pkg::st_idle:
            begin
                // reply captured as the frame opens so bit 31 is ready
                // before the first rising clock
                if (select_fall)
                begin
                    r_next.mode = host_port_pkg::st_receive;
                    r_next.bit_count = 6'h00;
                    r_next.tx_shift = reply;
                    r_next.shift_armed = 1'b0;
                    r_next.wait_count = 2'h0;
                end
            end
            host_port_pkg::st_receive:
            begin
                // extra clocks past 32 are ignored, not shifted in
                if (sclk_rise && (r_reg.bit_count != `DGRAM_COUNT_FULL))
                begin
                    r_next.rx_shift = {r_reg.rx_shift[30:0],
                        pins_sync.sdi};
                    r_next.bit_count = r_reg.bit_count + 6'h01;
                end
                // output moves only after the falling edge, never
                // within the wait, so the host keeps its sample window;
                // the first fall finds bit 31 already standing, so only
                // falls after a taken bit move the output on
                if (sclk_fall && (r_reg.bit_count != 6'h00))
                begin
                    r_next.shift_armed = 1'b1;
                    r_next.wait_count = 2'h0;
                end
                else if (r_reg.shift_armed)
                begin
                    if (r_reg.wait_count == `SDO_WAIT_CYC)
                    begin
                        r_next.tx_shift = {r_reg.tx_shift[30:0],
                            1'b0};
                        r_next.shift_armed = 1'b0;
                    end
                    else
                    begin
                        r_next.wait_count = r_reg.wait_count + 2'h1;
                    end
                end
                // short frames are dropped whole; long frames keep their first 32 bits
                if (select_rise)
                begin
                    r_next.mode = host_port_pkg::st_idle;
                    r_next.shift_armed = 1'b0;
                    if (r_reg.bit_count == `DGRAM_COUNT_FULL)
                    begin
                        r_next.buffer = r_reg.rx_shift;
                        r_next.buffer_valid = 1'b1;
                        // only writes bring new data for the chain
                        r_next.chain_update = !r_reg.rx_shift[24];
                        if (!r_reg.rx_shift[31] && !r_reg.rx_shift[24]
                            && (r_reg.rx_shift[30:25] == `PRESCALER_ADDR))
                        begin
                            r_next.chain_clock_prescaler =
                                r_reg.rx_shift[`PRESCALER_LSB +: 4];
                        end
                    end
                end
            end
        endcase
    end

    // everything clears at reset except the prescaler and the sclk and select copies, which load high
    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            r_reg <= '0;
            r_reg.sclk_q <= 1'b1;
            r_reg.select_n_q <= 1'b1;
            r_reg.buffer <= `DGRAM_RESET;
            r_reg.chain_clock_prescaler <= `CHAIN_PRESCALER_RESET;
        end
        else
        begin
            r_reg <= r_next;
        end
    end

    // combined pin: interrupt while idle or in direct mode, else data
    always_comb
    begin
        if (irq_direct || !selected)
        begin
            irq_or_serial_out_pin = irq_n;
        end
        else
        begin
            irq_or_serial_out_pin = r_reg.tx_shift[`DGRAM_MSB];
        end
    end

    // tristate copy carries data only, enabled only inside a frame
    assign host_serial_out_tristate = r_reg.tx_shift[`DGRAM_MSB];
    assign host_serial_out_tristate_oe = selected;
    assign datagram = r_reg.buffer;
    assign datagram_valid = r_reg.buffer_valid;
    assign chain_update = r_reg.chain_update;
    assign chain_clock_prescaler = r_reg.chain_clock_prescaler;

    // checks on the port behaviour
    property p_tristate_off;
        @(posedge core_clk) disable iff (!reset_n)
        (r_reg.select_n_q && pins_sync.select_n)
            |-> !host_serial_out_tristate_oe;
    endproperty
    a_tristate_off: assert property (p_tristate_off)
        else $error("tristate copy driven outside a frame");

    property p_idle_irq;
        @(posedge core_clk) disable iff (!reset_n)
        (r_reg.mode == host_port_pkg::st_idle || irq_direct)
            |-> (irq_or_serial_out_pin == irq_n);
    endproperty
    a_idle_irq: assert property (p_idle_irq)
        else $error("combined pin not showing interrupt");

    property p_tristate_data;
        @(posedge core_clk) disable iff (!reset_n)
        (selected && !irq_direct)
            |-> (host_serial_out_tristate == irq_or_serial_out_pin);
    endproperty
    a_tristate_data: assert property (p_tristate_data)
        else $error("tristate copy differs from frame data");

    property p_shift_in;
        @(posedge core_clk) disable iff (!reset_n)
        (selected && sclk_rise && r_reg.bit_count < `DGRAM_COUNT_FULL
            && !select_rise)
            |=> (r_reg.rx_shift[0] == $past(pins_sync.sdi))
            && (r_reg.bit_count == $past(r_reg.bit_count) + 6'h01);
    endproperty
    a_shift_in: assert property (p_shift_in)
        else $error("input bit not shifted on rising clock");

    property p_out_delay;
        @(posedge core_clk) disable iff (!reset_n)
        (selected && sclk_fall && r_reg.bit_count != 6'h00
            && !select_rise)
            |=> $stable(r_reg.tx_shift)
            ##1 (r_reg.tx_shift[31:1] == $past(r_reg.tx_shift[30:0], 2));
    endproperty
    a_out_delay: assert property (p_out_delay)
        else $error("output bit moved too early or not at all");

    property p_latch;
        @(posedge core_clk) disable iff (!reset_n)
        (selected && select_rise && r_reg.bit_count == `DGRAM_COUNT_FULL)
            |=> datagram_valid && (datagram == $past(r_reg.rx_shift));
    endproperty
    a_latch: assert property (p_latch)
        else $error("buffer not loaded at select release");

    property p_full_only;
        @(posedge core_clk) disable iff (!reset_n)
        datagram_valid |-> ($past(r_reg.bit_count) == `DGRAM_COUNT_FULL);
    endproperty
    a_full_only: assert property (p_full_only)
        else $error("datagram accepted with wrong length");

    property p_chain_write;
        @(posedge core_clk) disable iff (!reset_n)
        chain_update |-> (datagram_valid && !datagram.rw);
    endproperty
    a_chain_write: assert property (p_chain_write)
        else $error("chain update without a write datagram");

    property p_reply_load;
        @(posedge core_clk) disable iff (!reset_n)
        (r_reg.mode == host_port_pkg::st_idle && select_fall)
            |=> (r_reg.tx_shift == {$past(reply_status), $past(reply_data)});
    endproperty
    a_reply_load: assert property (p_reply_load)
        else $error("reply word not loaded at frame start");

    c_write: cover property (@(posedge core_clk) disable iff (!reset_n)
        datagram_valid && !datagram.rw);
    c_read: cover property (@(posedge core_clk) disable iff (!reset_n)
        datagram_valid && datagram.rw);
    c_short: cover property (@(posedge core_clk) disable iff (!reset_n)
        selected && select_rise && r_reg.bit_count != `DGRAM_COUNT_FULL);

endmodule // host_serial_datagram_port

// ---- test/host_master_model.sv ----
// host-side master model: drives select, serial clock and data of the port
// assumes core_clk from the bench as time base; counts are core_clk cycles
`timescale 1ns/10ps

module host_master_model
(
    input wire logic core_clk,  // time base only
    input wire logic sdo_pin,   // combined output pin
    input wire logic sdo_z,     // tristate copy as seen on the wire
    output logic sclk,          // serial clock, idles high
    output logic select_n,      // chip select, idles high
    output logic mosi           // serial data toward the port
);
    int early_changes = 0; // output bits that moved too soon after a fall

    initial
    begin
        sclk = 1'b1;
        select_n = 1'b1;
        mosi = 1'b1;
    end

    // let n edges pass, then act just after the last one
    task automatic cyc(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask

    // one frame of nbits, msb first; both outputs sampled on rising sclk
    task automatic frame(input logic [31:0] w, input int nbits,
        output logic [31:0] got_pin, output logic [31:0] got_z);
        logic held;
        select_n = 1'b0;
        cyc(4); // select setup, three cycles at least
        for (int i = 0; i < nbits; i++)
        begin
            sclk = 1'b0;
            mosi = w[31 - i];
            held = sdo_pin;
            cyc(3);
            if (sdo_pin !== held) early_changes++;
            cyc(2); // five low cycles leave margin over the output delay
            sclk = 1'b1;
            got_pin = {got_pin[30:0], sdo_pin};
            got_z = {got_z[30:0], sdo_z};
            cyc(4);
        end
        select_n = 1'b1;
        mosi = ~mosi; // released line must not keep a stale level
        cyc(4);
    endtask
endmodule // host_master_model

// ---- test/tb_host_serial_datagram_port.sv ----
// self-checking bench of the host serial datagram port
// assumes host_master_model as far side; the bench plays the device core
`timescale 1ns/10ps
`define CHECK(name, exp, got) \
    begin \
        n_compared++; \
        if ((got) !== (exp)) \
        begin \
            mismatches++; \
            $display("mismatch %s expected %h seen %h", name, exp, got); \
        end \
    end

module tb_host_serial_datagram_port;
    logic core_clk, reset_n, sclk, select_n, mosi, irq_n, irq_direct;
    logic [7:0] reply_status;
    logic [23:0] reply_data;
    logic pin, tri_data, oe, valid, update;
    logic [3:0] prescaler;
    host_port_pkg::datagram_t datagram;
    wire sdo_z = oe ? tri_data : 1'bz; // resolved level of the tristate pin
    int mismatches = 0;
    int n_compared = 0;
    int valid_seen = 0;
    int update_seen = 0;
    int dv, du;
    logic [31:0] got_pin, got_z, last;

    host_serial_datagram_port dut (.core_clk(core_clk), .reset_n(reset_n),
        .host_sclk(sclk), .host_select_n(select_n), .host_serial_in(mosi),
        .irq_n(irq_n), .irq_direct(irq_direct), .reply_status(reply_status),
        .reply_data(reply_data), .irq_or_serial_out_pin(pin),
        .host_serial_out_tristate(tri_data),
        .host_serial_out_tristate_oe(oe), .datagram(datagram),
        .datagram_valid(valid), .chain_update(update),
        .chain_clock_prescaler(prescaler));

    host_master_model host (.core_clk(core_clk), .sdo_pin(pin),
        .sdo_z(sdo_z), .sclk(sclk), .select_n(select_n), .mosi(mosi));

    initial
    begin
        core_clk = 1'b0;
        forever #10 core_clk = ~core_clk;
    end

    // pulses stand one cycle, so they are counted at every edge
    always @(posedge core_clk)
    begin
        if (valid === 1'b1) valid_seen++;
        if (update === 1'b1) update_seen++;
    end

    task automatic summarize();
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    // one frame with the reply words set first; pulse counts kept as deltas
    task automatic xfer(input logic [31:0] w, input int n,
        input logic [7:0] st, input logic [23:0] rd);
        int v0, u0;
        reply_status = st;
        reply_data = rd;
        v0 = valid_seen;
        u0 = update_seen;
        host.frame(w, n, got_pin, got_z);
        dv = valid_seen - v0;
        du = update_seen - u0;
    endtask

    task automatic t_reset();
        `CHECK("prescaler", 4'hf, prescaler)
        `CHECK("datagram", 32'h0000_0000, datagram)
        `CHECK("oe", 1'b0, oe)
        irq_n = 1'b0;
        host.cyc(1);
        `CHECK("idle pin low", 1'b0, pin)
        irq_n = 1'b1;
        host.cyc(1);
        `CHECK("idle pin high", 1'b1, pin)
        $display("test reset done");
    endtask

    // write then read back to back; reply and latch checked for each
    task automatic t_write_read();
        last = {1'b1, 6'h12, 1'b0, 24'h81_42_e7};
        xfer(last, 32, 8'ha5, 24'h3c_5a_96);
        `CHECK("reply pin", 32'ha53c_5a96, got_pin)
        `CHECK("reply z", 32'ha53c_5a96, got_z)
        `CHECK("datagram", last, datagram)
        `CHECK("valid count", 1, dv)
        `CHECK("update write", 1, du)
        `CHECK("early", 0, host.early_changes)
        `CHECK("oe idle", 1'b0, oe)
        `CHECK("pin idle", irq_n, pin)
        last = {1'b0, 6'h2d, 1'b1, 24'h00_00_00};
        xfer(last, 32, 8'h5a, 24'hff_00_01);
        `CHECK("reply read", 32'h5aff_0001, got_pin)
        `CHECK("datagram rd", last, datagram)
        `CHECK("valid rd", 1, dv)
        `CHECK("update read", 0, du)
        $display("test write_read done");
    endtask

    task automatic t_prescaler();
        last = {1'b0, 6'h3f, 1'b0, 24'h00_00_05};
        xfer(last, 32, 8'h00, 24'h00_00_00);
        `CHECK("prescaler", 4'h5, prescaler)
        `CHECK("update", 1, du)
        $display("test prescaler done");
    endtask

    // a frame one bit short must leave the buffer alone
    task automatic t_short();
        xfer(32'h7e_c3_81_18, 31, 8'h11, 24'h22_33_44);
        `CHECK("short valid", 0, dv)
        `CHECK("short update", 0, du)
        `CHECK("short keep", last, datagram)
        $display("test short done");
    endtask

    // direct interrupt mode: combined pin shows only the interrupt
    task automatic t_direct();
        irq_direct = 1'b1;
        irq_n = 1'b0;
        xfer({1'b1, 6'h01, 1'b1, 24'h0}, 32, 8'hc3, 24'h12_34_56);
        `CHECK("direct pin", 32'h0000_0000, got_pin)
        `CHECK("direct z", 32'hc312_3456, got_z)
        `CHECK("direct idle", 1'b0, pin)
        irq_n = 1'b1;
        irq_direct = 1'b0;
        host.cyc(1);
        $display("test direct done");
    endtask

    // reset in mid-run: prescaler back to fifteen, buffer cleared,
    // then the port must still take a frame
    task automatic t_reset_mid();
        `CHECK("prescaler set", 4'h5, prescaler)
        reset_n = 1'b0;
        host.cyc(2);
        `CHECK("prescaler rst", 4'hf, prescaler)
        `CHECK("datagram rst", 32'h0000_0000, datagram)
        `CHECK("oe rst", 1'b0, oe)
        reset_n = 1'b1;
        host.cyc(4);
        last = {1'b0, 6'h3f, 1'b0, 24'h00_00_0a};
        xfer(last, 32, 8'h00, 24'h00_00_00);
        `CHECK("prescaler again", 4'ha, prescaler)
        `CHECK("datagram again", last, datagram)
        $display("test reset_mid done");
    endtask

    initial
    begin
        reset_n = 1'b0;
        irq_n = 1'b1;
        irq_direct = 1'b0;
        reply_status = 8'h00;
        reply_data = 24'h00_00_00;
        repeat (16) @(posedge core_clk);
        #1;
        reset_n = 1'b1;
        t_reset();
        host.cyc(4); // host keeps off the port until reset is over
        t_write_read();
        t_prescaler();
        t_short();
        t_direct();
        t_reset_mid();
        summarize();
    end

    // six frames of about 300 cycles each; the limit leaves wide margin
    initial
    begin
        repeat (20000) @(posedge core_clk);
        mismatches++;
        $display("watchdog expired");
        summarize();
    end
endmodule // tb_host_serial_datagram_port
